// ==== common/smp_pkg.sv ====
package smp_pkg;
	// Timing reference and machine cycle
	localparam int OSC_KHZ      = 6000;
	localparam int MCYC_NS      = 2500;
	localparam int OSC_PER_MCYC = (MCYC_NS * OSC_KHZ) / 1000000;
	localparam logic [3:0] OSC_LAST = 4'(OSC_PER_MCYC - 1);
	localparam int CLK_MHZ      = 125;

	// Expander strobe phases, least time rounded up to clock cycles
	localparam int EXP_PHASE_NS  = 200;
	localparam int EXP_PHASE_CYC = (EXP_PHASE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] EXP_LAST = 8'(EXP_PHASE_CYC - 1);

	// Status byte layout
	localparam int ST_OBF     = 0;
	localparam int ST_IBF     = 1;
	localparam int ST_F0      = 2;
	localparam int ST_CMD     = 3;
	localparam int ST_USR_LSB = 4;

	// Second port field positions
	localparam int P2_ADDR_LSB = 0;
	localparam int P2_EXP_LSB  = 0;
	localparam int P2_FLAG_LSB = 4;
	localparam int P2_DMA_LSB  = 6;

	// Reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'hff;
	localparam logic [9:0] ADDR_RST = 10'h000;

	// Synchroniser bit positions
	localparam int SY_CS   = 0;
	localparam int SY_RD   = 1;
	localparam int SY_WR   = 2;
	localparam int SY_SEL  = 3;
	localparam int SY_OSC  = 4;
	localparam int SY_EXT  = 5;
	localparam int SY_TA   = 6;
	localparam int SY_TB   = 7;
	localparam int SY_SS   = 8;
	localparam int SY_BUS  = 9;
	localparam int SY_W    = 17;
endpackage

// ==== hdl/smp_pin_sync.sv ====
`timescale 1ns/10ps
module smp_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_q;

	// Accept a new level only once the two late stages agree
	always_comb begin
		nxt_q = q_ff;
		for (int i = 0; i < W; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_q[i] = s3_ff[i];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			q_ff  <= '0;
		end else if (i_ce) begin
			s1_ff <= i_d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff  <= nxt_q;
		end
	end

	assign o_q = q_ff;
endmodule // smp_pin_sync

// ==== hdl/smp_pin_if.sv ====
`timescale 1ns/10ps
module smp_pin_if
	import smp_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_cs_n,
	input  wire logic       i_rd_n,
	input  wire logic       i_wr_n,
	input  wire logic       i_host_cmd_status_sel,
	input  wire logic [7:0] i_host_bus_lines,
	output logic      [7:0] o_host_bus_lines,
	output logic            o_host_bus_lines_oe,
	input  wire logic       i_osc_in,
	output logic            o_osc_out,
	input  wire logic       i_external_fetch_select,
	input  wire logic       i_single_step_n,
	input  wire logic       i_test_input_a,
	input  wire logic       i_test_input_b,
	input  wire logic       i_fw_obuf_wr,
	input  wire logic [7:0] i_fw_obuf_data,
	input  wire logic       i_fw_ibuf_rd,
	input  wire logic       i_fw_flag0,
	input  wire logic [3:0] i_fw_status_hi,
	input  wire logic       i_two_cycle,
	input  wire logic [9:0] i_fetch_addr,
	input  wire logic [7:0] i_port1_data,
	input  wire logic [7:0] i_port2_data,
	input  wire logic       i_port2_alt,
	input  wire logic [1:0] i_flag_out,
	input  wire logic [1:0] i_dma_out,
	input  wire logic       i_exp_req,
	input  wire logic [3:0] i_exp_opcode,
	input  wire logic [3:0] i_exp_data,
	input  wire logic       i_counter_mode,
	output logic      [7:0] o_in_data,
	output logic            o_command_flag,
	output logic            o_in_buffer_full,
	output logic            o_out_buffer_full,
	output logic            o_sync,
	output logic            o_instr_end,
	output logic            o_stepping,
	output logic            o_fetch_external,
	output logic      [7:0] o_first_io_port,
	output logic      [7:0] o_second_io_port,
	output logic            o_expander_strobe,
	output logic            o_exp_busy,
	output logic            o_cond_test_a,
	output logic            o_cond_test_b,
	output logic            o_event_tick
);
	typedef enum logic [0:0] {ENG_RUN, ENG_HOLD} smp_eng_t;
	typedef enum logic [1:0] {EXP_IDLE, EXP_ADDR, EXP_DATA} smp_exp_t;

	logic [SY_W-1:0] pins;
	logic            cs_act, rd_act, wr_act, rd_start, rd_end, wr_end;
	logic            osc_rise, mcyc_end, tb_fall;

	// Host port state
	logic       rd_ff, wr_ff, rd_sel_ff, wr_sel_ff;
	logic [7:0] wr_data_ff, obuf_ff, ibuf_ff, bus_out_ff;
	logic       bus_oe_ff, cmd_ff, obf_ff, ibf_ff;
	logic       nxt_rd, nxt_wr, nxt_rd_sel, nxt_wr_sel;
	logic [7:0] nxt_wr_data, nxt_obuf, nxt_ibuf, nxt_bus_out;
	logic       nxt_bus_oe, nxt_cmd, nxt_obf, nxt_ibf;

	// Machine cycle engine state
	smp_eng_t   eng_ff, nxt_eng;
	logic [3:0] osc_cnt_ff, nxt_osc_cnt;
	logic       osc_prev_ff, nxt_osc_prev, left_ff, nxt_left;
	logic       sync_ff, nxt_sync, iend_ff, nxt_iend;
	logic [9:0] hold_addr_ff, nxt_hold_addr;
	logic       osc_out_ff, nxt_osc_out, ext_ff, nxt_ext;

	// Port and expander state
	smp_exp_t   exp_ff, nxt_exp;
	logic [7:0] exp_cnt_ff, nxt_exp_cnt, p1_ff, nxt_p1, p2_ff, nxt_p2;
	logic [3:0] exp_op_ff, nxt_exp_op, exp_dat_ff, nxt_exp_dat;
	logic       strb_ff, nxt_strb, busy_ff, nxt_busy;

	// Test input state
	logic       ta_ff, tb_ff, tb_prev_ff, tick_ff;
	logic       nxt_ta, nxt_tb, nxt_tb_prev, nxt_tick;

	// All pin inputs arrive asynchronously to i_clk
	smp_pin_sync #(.W(SY_W)) u_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_ce    (i_ce),
		.i_d     ({i_host_bus_lines, i_single_step_n, i_test_input_b, i_test_input_a,
		           i_external_fetch_select, i_osc_in, i_host_cmd_status_sel,
		           i_wr_n, i_rd_n, i_cs_n}),
		.o_q     (pins)
	);

	// Strobe decode, active low and gated by select
	assign cs_act   = !pins[SY_CS];
	assign rd_act   = cs_act && !pins[SY_RD];
	assign wr_act   = cs_act && !pins[SY_WR];
	assign rd_start = rd_act && !rd_ff;
	assign rd_end   = !rd_act && rd_ff;
	assign wr_end   = !wr_act && wr_ff;

	// Host buffers and flags; a firmware set wins over a host clear
	always_comb begin
		nxt_rd      = rd_act;
		nxt_wr      = wr_act;
		nxt_rd_sel  = rd_start ? pins[SY_SEL] : rd_sel_ff;
		nxt_wr_sel  = wr_act ? pins[SY_SEL] : wr_sel_ff;
		nxt_wr_data = wr_act ? pins[SY_BUS +: 8] : wr_data_ff;
		nxt_bus_oe  = rd_act;
		nxt_bus_out = bus_out_ff;
		if (rd_start) begin
			if (pins[SY_SEL]) begin
				nxt_bus_out = {i_fw_status_hi, cmd_ff, i_fw_flag0, ibf_ff, obf_ff};
			end else begin
				nxt_bus_out = obuf_ff;
			end
		end
		nxt_obuf = i_fw_obuf_wr ? i_fw_obuf_data : obuf_ff;
		nxt_obf  = (obf_ff && !(rd_end && !rd_sel_ff)) || i_fw_obuf_wr;
		nxt_ibuf = wr_end ? wr_data_ff : ibuf_ff;
		nxt_cmd  = wr_end ? wr_sel_ff : cmd_ff;
		nxt_ibf  = (ibf_ff && !i_fw_ibuf_rd) || wr_end;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_ff      <= 1'b0;
			wr_ff      <= 1'b0;
			rd_sel_ff  <= 1'b0;
			wr_sel_ff  <= 1'b0;
			wr_data_ff <= BYTE_RST;
			bus_oe_ff  <= 1'b0;
			bus_out_ff <= BYTE_RST;
			obuf_ff    <= BYTE_RST;
			obf_ff     <= 1'b0;
			ibuf_ff    <= BYTE_RST;
			cmd_ff     <= 1'b0;
			ibf_ff     <= 1'b0;
		end else if (i_ce) begin
			rd_ff      <= nxt_rd;
			wr_ff      <= nxt_wr;
			rd_sel_ff  <= nxt_rd_sel;
			wr_sel_ff  <= nxt_wr_sel;
			wr_data_ff <= nxt_wr_data;
			bus_oe_ff  <= nxt_bus_oe;
			bus_out_ff <= nxt_bus_out;
			obuf_ff    <= nxt_obuf;
			obf_ff     <= nxt_obf;
			ibuf_ff    <= nxt_ibuf;
			cmd_ff     <= nxt_cmd;
			ibf_ff     <= nxt_ibf;
		end
	end

	// Machine cycles counted on rising oscillator edges, crystal or logic clock alike
	assign osc_rise = pins[SY_OSC] && !osc_prev_ff;
	assign mcyc_end = osc_rise && (osc_cnt_ff == OSC_LAST);

	always_comb begin
		nxt_osc_prev  = pins[SY_OSC];
		nxt_osc_out   = !pins[SY_OSC];   // Feedback leg for a crystal
		nxt_ext       = pins[SY_EXT];
		nxt_eng       = eng_ff;
		nxt_osc_cnt   = osc_cnt_ff;
		nxt_left      = left_ff;
		nxt_sync      = 1'b0;
		nxt_iend      = 1'b0;
		nxt_hold_addr = hold_addr_ff;
		unique case (eng_ff)
			ENG_RUN: begin
				if (osc_rise) begin
					nxt_osc_cnt = mcyc_end ? 4'h0 : osc_cnt_ff + 4'h1;
				end
				if (mcyc_end) begin
					nxt_sync = 1'b1;
					if (left_ff) begin
						nxt_left = 1'b0;
					end else begin
						nxt_iend = 1'b1;
						nxt_left = i_two_cycle;
						if (!pins[SY_SS]) begin
							nxt_eng       = ENG_HOLD;
							nxt_hold_addr = i_fetch_addr;
						end
					end
				end
			end
			ENG_HOLD: begin
				// Execution resumes only while the step pin is released
				if (pins[SY_SS]) begin
					nxt_eng     = ENG_RUN;
					nxt_osc_cnt = 4'h0;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			eng_ff       <= ENG_RUN;
			osc_cnt_ff   <= 4'h0;
			osc_prev_ff  <= 1'b0;
			left_ff      <= 1'b0;
			sync_ff      <= 1'b0;
			iend_ff      <= 1'b0;
			hold_addr_ff <= ADDR_RST;
			osc_out_ff   <= 1'b0;
			ext_ff       <= 1'b0;
		end else if (i_ce) begin
			eng_ff       <= nxt_eng;
			osc_cnt_ff   <= nxt_osc_cnt;
			osc_prev_ff  <= nxt_osc_prev;
			left_ff      <= nxt_left;
			sync_ff      <= nxt_sync;
			iend_ff      <= nxt_iend;
			hold_addr_ff <= nxt_hold_addr;
			osc_out_ff   <= nxt_osc_out;
			ext_ff       <= nxt_ext;
		end
	end

	// Ports: stepping address beats expander, expander beats plain data
	always_comb begin
		nxt_exp     = exp_ff;
		nxt_exp_cnt = exp_cnt_ff;
		nxt_exp_op  = exp_op_ff;
		nxt_exp_dat = exp_dat_ff;
		nxt_strb    = 1'b0;
		nxt_busy    = 1'b1;
		unique case (exp_ff)
			EXP_IDLE: begin
				nxt_busy = 1'b0;
				if (i_exp_req) begin
					nxt_exp     = EXP_ADDR;
					nxt_exp_cnt = 8'h00;
					nxt_exp_op  = i_exp_opcode;
					nxt_exp_dat = i_exp_data;
					nxt_busy    = 1'b1;
				end
			end
			EXP_ADDR: begin
				nxt_exp_cnt = exp_cnt_ff + 8'h01;
				if (exp_cnt_ff == EXP_LAST) begin
					nxt_exp     = EXP_DATA;
					nxt_exp_cnt = 8'h00;
					nxt_strb    = 1'b1;
				end
			end
			EXP_DATA: begin
				nxt_strb    = 1'b1;
				nxt_exp_cnt = exp_cnt_ff + 8'h01;
				if (exp_cnt_ff == EXP_LAST) begin
					nxt_exp  = EXP_IDLE;
					nxt_strb = 1'b0;
				end
			end
			default: begin
				nxt_exp = EXP_IDLE;
			end
		endcase
		nxt_p1 = i_port1_data;
		nxt_p2 = i_port2_data;
		if (i_port2_alt) begin
			nxt_p2[P2_FLAG_LSB +: 2] = i_flag_out;
			nxt_p2[P2_DMA_LSB +: 2]  = i_dma_out;
		end
		if (nxt_exp == EXP_ADDR) begin
			nxt_p2[P2_EXP_LSB +: 4] = nxt_exp_op;
		end else if (nxt_exp == EXP_DATA) begin
			nxt_p2[P2_EXP_LSB +: 4] = exp_dat_ff;
		end
		if (eng_ff == ENG_HOLD) begin
			nxt_p1                   = hold_addr_ff[7:0];
			nxt_p2[P2_ADDR_LSB +: 2] = hold_addr_ff[9:8];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			exp_ff     <= EXP_IDLE;
			exp_cnt_ff <= 8'h00;
			exp_op_ff  <= 4'h0;
			exp_dat_ff <= 4'h0;
			strb_ff    <= 1'b0;
			busy_ff    <= 1'b0;
			p1_ff      <= PORT_RST;
			p2_ff      <= PORT_RST;
		end else if (i_ce) begin
			exp_ff     <= nxt_exp;
			exp_cnt_ff <= nxt_exp_cnt;
			exp_op_ff  <= nxt_exp_op;
			exp_dat_ff <= nxt_exp_dat;
			strb_ff    <= nxt_strb;
			busy_ff    <= nxt_busy;
			p1_ff      <= nxt_p1;
			p2_ff      <= nxt_p2;
		end
	end

	// Test inputs; the counter counts falling edges of the second one
	assign tb_fall = tb_prev_ff && !pins[SY_TB];

	always_comb begin
		nxt_ta      = pins[SY_TA];
		nxt_tb      = pins[SY_TB];
		nxt_tb_prev = pins[SY_TB];
		nxt_tick    = tb_fall && i_counter_mode;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ta_ff      <= 1'b0;
			tb_ff      <= 1'b0;
			tb_prev_ff <= 1'b0;
			tick_ff    <= 1'b0;
		end else if (i_ce) begin
			ta_ff      <= nxt_ta;
			tb_ff      <= nxt_tb;
			tb_prev_ff <= nxt_tb_prev;
			tick_ff    <= nxt_tick;
		end
	end

	assign o_host_bus_lines    = bus_out_ff;
	assign o_host_bus_lines_oe = bus_oe_ff;
	assign o_osc_out           = osc_out_ff;
	assign o_in_data           = ibuf_ff;
	assign o_command_flag      = cmd_ff;
	assign o_in_buffer_full    = ibf_ff;
	assign o_out_buffer_full   = obf_ff;
	assign o_sync              = sync_ff;
	assign o_instr_end         = iend_ff;
	assign o_stepping          = (eng_ff == ENG_HOLD);
	assign o_fetch_external    = ext_ff;
	assign o_first_io_port     = p1_ff;
	assign o_second_io_port    = p2_ff;
	assign o_expander_strobe   = strb_ff;
	assign o_exp_busy          = busy_ff;
	assign o_cond_test_a       = ta_ff;
	assign o_cond_test_b       = tb_ff;
	assign o_event_tick        = tick_ff;

	// Checks on the block's own behaviour
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_exp_go;
		i_ce && i_exp_req && (exp_ff == EXP_IDLE);
	endsequence
	sequence s_strobe_seen;
		##[1:80] o_expander_strobe;
	endsequence

	a_unsel_quiet: assert property ((!cs_act && i_ce) |=> !o_host_bus_lines_oe)
		else $error("bus driven without select");
	a_data_read: assert property ((rd_start && !pins[SY_SEL] && i_ce)
		|=> (o_host_bus_lines == $past(obuf_ff)))
		else $error("data read returned wrong byte");
	a_status_read: assert property ((rd_start && pins[SY_SEL] && i_ce)
		|=> (o_host_bus_lines[ST_OBF] == $past(obf_ff)))
		else $error("status read lost out-full bit");
	a_write_capture: assert property ((wr_end && i_ce)
		|=> (o_in_data == $past(wr_data_ff)) && o_in_buffer_full)
		else $error("write not captured");
	a_cmd_flag_set: assert property ((wr_end && i_ce)
		|=> (o_command_flag == $past(wr_sel_ff)))
		else $error("command flag wrong");
	a_obf_set_wins: assert property ((i_fw_obuf_wr && i_ce) |=> o_out_buffer_full)
		else $error("out-full not set");
	a_status_no_effect: assert property ((rd_end && rd_sel_ff && i_ce && !i_fw_ibuf_rd)
		|=> (o_out_buffer_full == $past(obf_ff)) && (o_in_buffer_full == $past(ibf_ff)))
		else $error("status read changed flags");
	a_sync_single: assert property (o_sync |=> !o_sync[*8])
		else $error("sync pulse too long");
	a_exp_strobe: assert property (s_exp_go |-> s_strobe_seen)
		else $error("expander strobe missing");
	a_step_addr: assert property ((o_stepping && $past(o_stepping) && i_ce && $past(i_ce))
		|=> (o_first_io_port == $past(hold_addr_ff[7:0])))
		else $error("step address not shown");
	a_event_tick: assert property ((tb_fall && i_counter_mode && i_ce) |=> o_event_tick)
		else $error("event edge missed");
endmodule // smp_pin_if

// ==== tb/smp_host_model.sv ====
`timescale 1ns/10ps
// Master processor on the parallel host port
module smp_host_model (
	input  wire logic       i_clk,
	input  wire logic       i_oe,
	input  wire logic [7:0] i_bus,
	output logic            o_cs_n,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic            o_sel,
	output logic      [7:0] o_bus
);
	// Idle host: select and strobes high
	initial begin
		o_cs_n = 1'b1;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_sel  = 1'b0;
		o_bus  = 8'h00;
	end

	// Write cycle; after release the bus no longer shows the byte
	task automatic host_wr(input logic cs, input logic sel, input logic [7:0] d);
		@(posedge i_clk);
		o_cs_n <= ~cs;
		o_sel  <= sel;
		o_bus  <= d;
		o_wr_n <= 1'b0;
		repeat (6) @(posedge i_clk);
		o_wr_n <= 1'b1;
		o_cs_n <= 1'b1;
		@(posedge i_clk);
		o_bus <= ~d;
		repeat (8) @(posedge i_clk);
	endtask

	// Read cycle; held until the enable is seen at an edge, at most 20 edges
	task automatic host_rd(input logic cs, input logic sel, output logic [7:0] d,
			output logic ok);
		int k;
		ok = 1'b0;
		d  = 8'h00;
		@(posedge i_clk);
		o_cs_n <= ~cs;
		o_sel  <= sel;
		o_rd_n <= 1'b0;
		for (k = 0; k < 20 && !ok; k++) begin
			@(posedge i_clk);
			if (i_oe === 1'b1) begin
				ok = 1'b1;
				d  = i_bus;
			end
		end
		o_rd_n <= 1'b1;
		o_cs_n <= 1'b1;
		repeat (10) @(posedge i_clk);
	endtask
endmodule // smp_host_model

// ==== tb/slave_mcu_pin_interface_test.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin $display("[FAIL] %s exp %h got %h", nm, ex, gt); fails++; end end
module slave_mcu_pin_interface_test;
	import smp_pkg::*;
	logic       i_clk, i_rst_n, i_osc_in, i_efs, i_ss_n, i_ta, i_tb;
	logic       i_obw, i_ibr, i_two, i_alt, i_xreq, i_cmode;
	logic [7:0] i_obd;
	logic [3:0] i_xop, i_xd;
	logic [1:0] i_flg, i_dma;
	logic       cs_n, rd_n, wr_n, sel, oe, fw_f0;
	logic [7:0] hbus, dbus, in_data, p1, p2, rd;
	logic       cmdf, in_buffer_full, out_buffer_full, sync, iend, stp, fext, xstb, xbusy, ca, cb, tick, ok;
	int         fails, total_checks, n, k, osc_cnt;

	// Wire level: device drives while enabled, else the host
	smp_host_model u_host (.i_clk(i_clk), .i_oe(oe), .i_bus(dbus), .o_cs_n(cs_n),
		.o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel(sel), .o_bus(hbus));
	smp_pin_if u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_cs_n(cs_n),
		.i_rd_n(rd_n), .i_wr_n(wr_n), .i_host_cmd_status_sel(sel),
		.i_host_bus_lines(oe ? dbus : hbus), .o_host_bus_lines(dbus),
		.o_host_bus_lines_oe(oe), .i_osc_in(i_osc_in), .o_osc_out(),
		.i_external_fetch_select(i_efs), .i_single_step_n(i_ss_n), .i_test_input_a(i_ta),
		.i_test_input_b(i_tb), .i_fw_obuf_wr(i_obw), .i_fw_obuf_data(i_obd),
		.i_fw_ibuf_rd(i_ibr), .i_fw_flag0(fw_f0), .i_fw_status_hi(4'ha), .i_two_cycle(i_two),
		.i_fetch_addr(10'h2b7), .i_port1_data(8'h3c), .i_port2_data(8'h5a),
		.i_port2_alt(i_alt), .i_flag_out(i_flg), .i_dma_out(i_dma), .i_exp_req(i_xreq),
		.i_exp_opcode(i_xop), .i_exp_data(i_xd), .i_counter_mode(i_cmode), .o_in_data(in_data),
		.o_command_flag(cmdf), .o_in_buffer_full(in_buffer_full), .o_out_buffer_full(out_buffer_full),
		.o_sync(sync), .o_instr_end(iend), .o_stepping(stp), .o_fetch_external(fext),
		.o_first_io_port(p1), .o_second_io_port(p2), .o_expander_strobe(xstb),
		.o_exp_busy(xbusy), .o_cond_test_a(ca), .o_cond_test_b(cb), .o_event_tick(tick));

	// Clock, 8 ns period
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// Oscillator pin at ten clocks a period, slow enough for the filter
	always @(posedge i_clk) begin
		osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
		if (osc_cnt == 4)
			i_osc_in <= ~i_osc_in;
	end

	// Cycles between two pulses of sync or instruction end
	task automatic gap(input bit ie, output int g);
		int w;
		for (w = 0; w < 1000 && (ie ? iend : sync) !== 1'b1; w++) @(negedge i_clk);
		@(negedge i_clk);
		for (g = 1; g < 1000 && (ie ? iend : sync) !== 1'b1; g++) @(negedge i_clk);
	endtask

	task automatic report_and_stop();
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, far beyond the few thousand cycles needed
	initial begin
		#(8 * 40000);
		fails++;
		report_and_stop();
	end

	initial begin
		{i_rst_n, i_osc_in, i_efs, i_ta, i_tb, i_obw, i_ibr, i_two, i_alt, i_xreq, i_cmode} = '0;
		{i_flg, i_dma, i_xop, i_xd, i_obd} = '0;
		i_ss_n = 1'b1;
		fw_f0 = 1'b1;
		osc_cnt = 0;
		fails = 0;
		total_checks = 0;
		repeat (20) @(posedge i_clk);
		`CHK("oe", 1'b0, oe)
		`CHK("flags", 3'b000, {cmdf, in_buffer_full, out_buffer_full})
		`CHK("ports", 16'hffff, {p1, p2})
		i_rst_n <= 1'b1;
		repeat (6) @(posedge i_clk);
		// Host writes, data then command, with a firmware read between
		u_host.host_wr(1'b1, 1'b0, 8'ha5);
		`CHK("in_data", 8'ha5, in_data)
		`CHK("cmd_ibf", 2'b01, {cmdf, in_buffer_full})
		@(posedge i_clk) i_ibr <= 1'b1;
		@(posedge i_clk) i_ibr <= 1'b0;
		repeat (2) @(negedge i_clk);
		`CHK("ibf_clr", 1'b0, in_buffer_full)
		u_host.host_wr(1'b1, 1'b1, 8'h3c);
		`CHK("cmd_in", 10'h33c, {cmdf, in_buffer_full, in_data})
		// Strobes while deselected must change nothing
		u_host.host_wr(1'b0, 1'b0, 8'h81);
		`CHK("desel_wr", 10'h33c, {cmdf, in_buffer_full, in_data})
		u_host.host_rd(1'b0, 1'b0, rd, ok);
		`CHK("desel_rd", 1'b0, ok)
		// Status read twice; second equal proves no side effect
		for (k = 0; k < 2; k++) begin
			u_host.host_rd(1'b1, 1'b1, rd, ok);
			`CHK("status", 9'h1ae, {ok, rd})
		end
		// Firmware flag bit must follow its input in the status byte
		@(posedge i_clk) fw_f0 <= 1'b0;
		u_host.host_rd(1'b1, 1'b1, rd, ok);
		`CHK("status_f0", 9'h1aa, {ok, rd})
		// Firmware fills output buffer, host data read empties it
		@(posedge i_clk) begin
			i_obw <= 1'b1;
			i_obd <= 8'hc3;
		end
		@(posedge i_clk) i_obw <= 1'b0;
		@(negedge i_clk);
		`CHK("obf_set", 1'b1, out_buffer_full)
		u_host.host_rd(1'b1, 1'b0, rd, ok);
		`CHK("obuf", 9'h1c3, {ok, rd})
		`CHK("obf_clr", 1'b0, out_buffer_full)
		// Expander transfer: opcode phase, then strobed data phase
		@(posedge i_clk) begin
			i_xreq <= 1'b1;
			i_xop  <= 4'h9;
			i_xd   <= 4'h6;
		end
		@(posedge i_clk) i_xreq <= 1'b0;
		@(negedge i_clk);
		`CHK("xop", 5'h19, {xbusy, p2[3:0]})
		for (k = 0; k < 60 && xstb !== 1'b1; k++) @(negedge i_clk);
		`CHK("xdat", 4'h6, p2[3:0])
		for (n = 0; n < 60 && xstb === 1'b1; n++) @(negedge i_clk);
		`CHK("xstb_len", EXP_PHASE_CYC, n)
		// Machine cycle and two-cycle instruction lengths in clocks
		gap(1'b0, n);
		`CHK("mcyc", OSC_PER_MCYC * 10, n)
		@(posedge i_clk) i_two <= 1'b1;
		gap(1'b1, n);
		gap(1'b1, n);
		`CHK("two_cyc", OSC_PER_MCYC * 20, n)
		@(posedge i_clk) i_two <= 1'b0;
		// Single step halts and shows the next fetch address
		@(posedge i_clk) i_ss_n <= 1'b0;
		for (k = 0; k < 700 && stp !== 1'b1; k++) @(negedge i_clk);
		@(negedge i_clk);
		`CHK("step_addr", 11'h6b7, {stp, p2[1:0], p1})
		@(posedge i_clk) i_ss_n <= 1'b1;
		for (k = 0; k < 20 && stp === 1'b1; k++) @(negedge i_clk);
		`CHK("step_go", 1'b0, stp)
		// Flag and handshake outputs, pins and test levels
		@(posedge i_clk) begin
			i_alt <= 1'b1;
			i_flg <= 2'b01;
			i_dma <= 2'b10;
			i_efs <= 1'b1;
			i_ta  <= 1'b1;
			i_tb  <= 1'b1;
			i_cmode <= 1'b1;
		end
		repeat (10) @(negedge i_clk);
		`CHK("p2_hi", 4'h9, p2[7:4])
		`CHK("ext", 1'b1, fext)
		`CHK("tests", 2'b11, {ca, cb})
		// One event tick per falling edge only in counter mode
		for (k = 0; k < 2; k++) begin
			@(posedge i_clk) i_tb <= 1'b0;
			n = 0;
			repeat (15) begin
				@(negedge i_clk);
				n += int'(tick === 1'b1);
			end
			`CHK("ticks", 1 - k, n)
			@(posedge i_clk) begin
				i_tb <= 1'b1;
				i_cmode <= 1'b0;
			end
			repeat (10) @(posedge i_clk);
		end
		report_and_stop();
	end
endmodule // slave_mcu_pin_interface_test
